// ==== logic/wdsl_counter.sv ====
// 32-bit down counter of the watchdog with reload and a one-cycle timeout pulse.
// Assumes run, load_now and load_val come from logic on mclk.
`timescale 1ns/1ps
`include "wdsl_params.svh"

module wdsl_counter (
   input  wire logic        mclk,
   input  wire logic        sys_rst,
   input  wire logic        ce,
   input  wire logic        run,
   input  wire logic        load_now,
   input  wire logic [31:0] load_val,
   output logic      [31:0] value,
   output logic             timeout
);

   wdsl_pkg::wdsl_cnt_st_t cnt_ff;
   wdsl_pkg::wdsl_cnt_st_t nxt_cnt;

   // -------------------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------------------
   // A reload request wins over counting so a clear or a new reload value
   // always restarts the interval from the full value.
   always_comb begin
      nxt_cnt     = cnt_ff;
      nxt_cnt.tmo = 1'b0;
      if (load_now) begin
         nxt_cnt.cnt = load_val;
      end else if (run) begin
         if (cnt_ff.cnt == 32'h00000000) begin
            nxt_cnt.tmo = 1'b1;
            nxt_cnt.cnt = load_val;
         end else begin
            nxt_cnt.cnt = cnt_ff.cnt - 32'h00000001;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         cnt_ff <= '{cnt: `WDSL_RELOAD_RST, tmo: 1'b0};
      end else if (ce) begin
         cnt_ff <= nxt_cnt;
      end
   end

   assign value   = cnt_ff.cnt;
   assign timeout = cnt_ff.tmo;

endmodule : wdsl_counter

// ==== logic/wdsl_ident.sv ====
// Fixed identification bytes, one per register, selected by address.
// Assumes the caller has already decided that the address is an identifier slot.
`timescale 1ns/1ps
`include "wdsl_params.svh"

module wdsl_ident #(
   parameter logic [7:0] ID_BYTE_0 = 8'h3c, // Value is arbitrary.
   parameter logic [7:0] ID_BYTE_1 = 8'h18,
   parameter logic [7:0] ID_BYTE_4 = 8'h4b, // Value is arbitrary.
   parameter logic [7:0] ID_BYTE_5 = 8'h6d, // Value is arbitrary.
   parameter logic [7:0] ID_BYTE_6 = 8'h72, // Value is arbitrary.
   parameter logic [7:0] ID_BYTE_7 = 8'h81  // Value is arbitrary.
) (
   input  wire logic [11:0] addr,
   output logic      [31:0] word
);

   // -------------------------------------------------------------------------
   // Lookup
   // -------------------------------------------------------------------------
   // The upper 24 bits are tied to zero; nothing can write these words.
   always_comb begin
      word = 32'h00000000;
      case (addr)
         `WDSL_OFS_ID4: word[7:0] = ID_BYTE_4;
         `WDSL_OFS_ID5: word[7:0] = ID_BYTE_5;
         `WDSL_OFS_ID6: word[7:0] = ID_BYTE_6;
         `WDSL_OFS_ID7: word[7:0] = ID_BYTE_7;
         `WDSL_OFS_ID0: word[7:0] = ID_BYTE_0;
         `WDSL_OFS_ID1: word[7:0] = ID_BYTE_1;
         default:       word      = 32'h00000000;
      endcase
   end

endmodule : wdsl_ident

// ==== logic/wdsl_params.svh ====
// Register offsets, field positions, reset values and the unlock key of the watchdog
// status, lock and identification block.
// Assumes a 12-bit byte address within the block and 32-bit data words.
`ifndef WDSL_PARAMS_SVH
`define WDSL_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define WDSL_OFS_RELOAD      12'h000
`define WDSL_OFS_VALUE       12'h004
`define WDSL_OFS_CTRL        12'h008
`define WDSL_OFS_CLEAR       12'h00c
`define WDSL_OFS_RAW_STAT    12'h010
`define WDSL_OFS_MASK_STAT   12'h014
`define WDSL_OFS_EVT_STAT    12'h020
`define WDSL_OFS_EVT_MASK    12'h024
`define WDSL_OFS_LOCK        12'hc00
`define WDSL_OFS_ID4         12'hfd0
`define WDSL_OFS_ID5         12'hfd4
`define WDSL_OFS_ID6         12'hfd8
`define WDSL_OFS_ID7         12'hfdc
`define WDSL_OFS_ID0         12'hfe0
`define WDSL_OFS_ID1         12'hfe4

// ----------------------------------------------------------------------------
// Field positions and values
// ----------------------------------------------------------------------------
`define WDSL_CTRL_IRQ_EN     0
`define WDSL_CTRL_RST_EN     1
`define WDSL_EVT_TIMEOUT     0
`define WDSL_EVT_RESET       1
`define WDSL_UNLOCK_KEY      32'h1acce551
`define WDSL_RELOAD_RST      32'hffffffff
`define WDSL_LOCKED_READ     32'h00000001
`define WDSL_UNLOCKED_READ   32'h00000000

`endif

// ==== logic/wdsl_pkg.sv ====
// Types shared by the watchdog status, lock and identification block.
// Assumes the offsets and reset values come from wdsl_params.svh.
package wdsl_pkg;

   // -------------------------------------------------------------------------
   // Register port request
   // -------------------------------------------------------------------------
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [11:0] addr;
      logic [31:0] wdata;
   } wdsl_bus_req_t;

   // -------------------------------------------------------------------------
   // Register selection after address decode
   // -------------------------------------------------------------------------
   typedef enum logic [3:0] {
      WDSL_SEL_NONE,
      WDSL_SEL_RELOAD,
      WDSL_SEL_VALUE,
      WDSL_SEL_CTRL,
      WDSL_SEL_CLEAR,
      WDSL_SEL_RAW,
      WDSL_SEL_MASKED,
      WDSL_SEL_EVT_STAT,
      WDSL_SEL_EVT_MASK,
      WDSL_SEL_LOCK,
      WDSL_SEL_IDENT
   } wdsl_sel_t;

   // -------------------------------------------------------------------------
   // Module state
   // -------------------------------------------------------------------------
   typedef struct packed {
      logic [31:0] cnt;
      logic        tmo;
   } wdsl_cnt_st_t;

   typedef struct packed {
      logic [31:0] reload;
      logic        irq_en;
      logic        rst_en;
      logic        raw;
      logic        locked;
      logic        rst_req;
      logic [1:0]  evt_stat;
      logic [1:0]  evt_mask;
      logic [31:0] rdata;
   } wdsl_st_t;

endpackage : wdsl_pkg

// ==== logic/wdsl_top.sv ====
// Watchdog register block: reload and control, timeout status, write lock,
// event interrupt and identification words.
// Assumes a single-cycle register port on mclk; read data appear one cycle
// after the read strobe and stand for that cycle only.
//
// Notes on behaviour
// - Raw status bit 0 shows timeout state before enable masking; upper bits zero.
// - Masked status bit 0 is raw status AND the interrupt enable bit.
// - Writing the unlock key to the lock register opens all other registers.
// - Writing any other value locks; locked writes to other registers do nothing.
// - Lock register reads one when locked and zero when unlocked.
// - Identification registers are constant and ignore every write.
// - Each identification register holds one identifier byte in bits 7:0.
// - Enabled counter hitting zero sets raw status and reloads, counting on.
// - Any unlocked write to the clear register clears raw status and reloads the counter.
`timescale 1ns/1ps
`include "wdsl_params.svh"

module wdsl_top #(
   parameter logic [7:0] ID_BYTE_0 = 8'h3c, // Value is arbitrary.
   parameter logic [7:0] ID_BYTE_1 = 8'h18,
   parameter logic [7:0] ID_BYTE_4 = 8'h4b, // Value is arbitrary.
   parameter logic [7:0] ID_BYTE_5 = 8'h6d, // Value is arbitrary.
   parameter logic [7:0] ID_BYTE_6 = 8'h72, // Value is arbitrary.
   parameter logic [7:0] ID_BYTE_7 = 8'h81  // Value is arbitrary.
) (
   input  wire logic                   mclk,
   input  wire logic                   sys_rst,
   input  wire logic                   ce,
   input  wire wdsl_pkg::wdsl_bus_req_t bus_req,
   output logic                 [31:0] rdata,
   output logic                        timeout_interrupt,
   output logic                        sys_reset_req,
   output logic                        irq
);

   // -------------------------------------------------------------------------
   // Address decode
   // -------------------------------------------------------------------------
   // Shared by the write path and the read path so both agree on the map.
   function automatic wdsl_pkg::wdsl_sel_t decode(input logic [11:0] a);
      case (a)
         `WDSL_OFS_RELOAD:    decode = wdsl_pkg::WDSL_SEL_RELOAD;
         `WDSL_OFS_VALUE:     decode = wdsl_pkg::WDSL_SEL_VALUE;
         `WDSL_OFS_CTRL:      decode = wdsl_pkg::WDSL_SEL_CTRL;
         `WDSL_OFS_CLEAR:     decode = wdsl_pkg::WDSL_SEL_CLEAR;
         `WDSL_OFS_RAW_STAT:  decode = wdsl_pkg::WDSL_SEL_RAW;
         `WDSL_OFS_MASK_STAT: decode = wdsl_pkg::WDSL_SEL_MASKED;
         `WDSL_OFS_EVT_STAT:  decode = wdsl_pkg::WDSL_SEL_EVT_STAT;
         `WDSL_OFS_EVT_MASK:  decode = wdsl_pkg::WDSL_SEL_EVT_MASK;
         `WDSL_OFS_LOCK:      decode = wdsl_pkg::WDSL_SEL_LOCK;
         `WDSL_OFS_ID4,
         `WDSL_OFS_ID5,
         `WDSL_OFS_ID6,
         `WDSL_OFS_ID7,
         `WDSL_OFS_ID0,
         `WDSL_OFS_ID1:       decode = wdsl_pkg::WDSL_SEL_IDENT;
         default:             decode = wdsl_pkg::WDSL_SEL_NONE;
      endcase
   endfunction : decode

   // -------------------------------------------------------------------------
   // Declarations
   // -------------------------------------------------------------------------
   localparam wdsl_pkg::wdsl_st_t ST_RST = '{
      reload:   `WDSL_RELOAD_RST,
      irq_en:   1'b0,
      rst_en:   1'b0,
      raw:      1'b0,
      locked:   1'b0,
      rst_req:  1'b0,
      evt_stat: 2'b00,
      evt_mask: 2'b00,
      rdata:    32'h00000000
   };

   wdsl_pkg::wdsl_st_t  st_ff;
   wdsl_pkg::wdsl_st_t  nxt_st;
   wdsl_pkg::wdsl_sel_t sel;
   logic                wr_ok;
   logic                clr_wr;
   logic                load_now;
   logic                cnt_tmo;
   logic         [31:0] cnt_val;
   logic         [31:0] id_word;
   logic          [1:0] evt_set;

   assign sel = decode(bus_req.addr);

   // The lock register itself stays writable so software can always reopen.
   assign wr_ok  = bus_req.wr & (~st_ff.locked | (sel == wdsl_pkg::WDSL_SEL_LOCK));
   assign clr_wr = wr_ok & (sel == wdsl_pkg::WDSL_SEL_CLEAR);

   // A reload write, a clear, or the enable being turned on restarts the
   // interval from the reload value rather than from the last count.
   always_comb begin
      load_now = 1'b0;
      if (wr_ok && sel == wdsl_pkg::WDSL_SEL_RELOAD) begin
         load_now = 1'b1;
      end
      if (clr_wr) begin
         load_now = 1'b1;
      end
      if (wr_ok && sel == wdsl_pkg::WDSL_SEL_CTRL && !st_ff.irq_en
          && bus_req.wdata[`WDSL_CTRL_IRQ_EN]) begin
         load_now = 1'b1;
      end
   end

   // -------------------------------------------------------------------------
   // Counter and identification words
   // -------------------------------------------------------------------------
   wdsl_counter u_counter (
      .mclk     (mclk),
      .sys_rst  (sys_rst),
      .ce       (ce),
      .run      (st_ff.irq_en),
      .load_now (load_now),
      .load_val (nxt_st.reload),
      .value    (cnt_val),
      .timeout  (cnt_tmo)
   );

   wdsl_ident #(
      .ID_BYTE_0 (ID_BYTE_0),
      .ID_BYTE_1 (ID_BYTE_1),
      .ID_BYTE_4 (ID_BYTE_4),
      .ID_BYTE_5 (ID_BYTE_5),
      .ID_BYTE_6 (ID_BYTE_6),
      .ID_BYTE_7 (ID_BYTE_7)
   ) u_ident (
      .addr (bus_req.addr),
      .word (id_word)
   );

   // -------------------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------------------
   always_comb begin
      nxt_st       = st_ff;
      nxt_st.rdata = 32'h00000000;
      evt_set      = 2'b00;

      // Register writes. Raw and masked status, value and identifier words have no write path.
      if (wr_ok) begin
         case (sel)
            wdsl_pkg::WDSL_SEL_RELOAD: begin
               nxt_st.reload = bus_req.wdata;
            end
            wdsl_pkg::WDSL_SEL_CTRL: begin
               // Once the enable is set the control word is frozen until reset.
               if (!st_ff.irq_en) begin
                  nxt_st.irq_en = bus_req.wdata[`WDSL_CTRL_IRQ_EN];
                  nxt_st.rst_en = bus_req.wdata[`WDSL_CTRL_RST_EN];
               end
            end
            wdsl_pkg::WDSL_SEL_EVT_STAT: begin
               nxt_st.evt_stat = st_ff.evt_stat & ~bus_req.wdata[1:0];
            end
            wdsl_pkg::WDSL_SEL_EVT_MASK: begin
               nxt_st.evt_mask = bus_req.wdata[1:0];
            end
            wdsl_pkg::WDSL_SEL_LOCK: begin
               nxt_st.locked = (bus_req.wdata != `WDSL_UNLOCK_KEY);
            end
            default: begin
               nxt_st.locked = st_ff.locked;
            end
         endcase
      end

      // Raw timeout status: a timeout in the same cycle as a clear wins.
      if (clr_wr) begin
         nxt_st.raw = 1'b0;
      end
      if (cnt_tmo) begin
         nxt_st.raw = 1'b1;
         evt_set[`WDSL_EVT_TIMEOUT] = 1'b1;
      end

      // A second timeout with the first still pending asks for a system reset when the reset enable is set.
      // The request holds until sys_rst because the system is expected to act on it.
      if (cnt_tmo && st_ff.raw && !clr_wr && st_ff.rst_en) begin
         nxt_st.rst_req = 1'b1;
         evt_set[`WDSL_EVT_RESET] = 1'b1;
      end

      // Sticky event bits: hardware set wins over a write-one clear.
      nxt_st.evt_stat = nxt_st.evt_stat | evt_set;

      // Read data, registered so they appear in the cycle after the strobe.
      if (bus_req.rd) begin
         case (sel)
            wdsl_pkg::WDSL_SEL_RELOAD:   nxt_st.rdata = st_ff.reload;
            wdsl_pkg::WDSL_SEL_VALUE:    nxt_st.rdata = cnt_val;
            wdsl_pkg::WDSL_SEL_CTRL: begin
               nxt_st.rdata[`WDSL_CTRL_IRQ_EN] = st_ff.irq_en;
               nxt_st.rdata[`WDSL_CTRL_RST_EN] = st_ff.rst_en;
            end
            wdsl_pkg::WDSL_SEL_RAW: begin
               nxt_st.rdata[0] = st_ff.raw;
            end
            wdsl_pkg::WDSL_SEL_MASKED: begin
               nxt_st.rdata[0] = st_ff.raw & st_ff.irq_en;
            end
            wdsl_pkg::WDSL_SEL_EVT_STAT: nxt_st.rdata[1:0] = st_ff.evt_stat;
            wdsl_pkg::WDSL_SEL_EVT_MASK: nxt_st.rdata[1:0] = st_ff.evt_mask;
            wdsl_pkg::WDSL_SEL_LOCK: begin
               nxt_st.rdata = st_ff.locked ? `WDSL_LOCKED_READ
                                           : `WDSL_UNLOCKED_READ;
            end
            wdsl_pkg::WDSL_SEL_IDENT:    nxt_st.rdata = id_word;
            default:                     nxt_st.rdata = 32'h00000000;
         endcase
      end
   end

   // -------------------------------------------------------------------------
   // State register
   // -------------------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         st_ff <= ST_RST;
      end else if (ce) begin
         st_ff <= nxt_st;
      end
   end

   // -------------------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------------------
   assign rdata             = st_ff.rdata;
   assign timeout_interrupt = st_ff.raw & st_ff.irq_en;
   assign sys_reset_req     = st_ff.rst_req;
   assign irq               = |(st_ff.evt_stat & st_ff.evt_mask);

endmodule : wdsl_top

// ==== tb/tb_top.sv ====
// Self-checking testbench for the watchdog status, lock and identification block.
// Assumes wdsl_top with its register port on mclk and the checker bound to it.
`timescale 1ns/1ps
`include "wdsl_params.svh"

module tb_top;
   // Identification bytes; all but byte one are arbitrary values.
   localparam logic [7:0] IDB [6] = '{8'h4b, 8'h6d, 8'h72, 8'h81, 8'h3c, 8'h18};
   logic                    mclk;
   logic                    sys_rst;
   logic                    ce;
   wdsl_pkg::wdsl_bus_req_t bus_req;
   logic             [31:0] rdata;
   logic                    timeout_interrupt;
   logic                    sys_reset_req;
   logic                    irq;
   logic             [31:0] rv;
   int                      err_total;
   int                      checks_done;

   wdsl_top #(.ID_BYTE_4(IDB[0]), .ID_BYTE_5(IDB[1]), .ID_BYTE_6(IDB[2]),
      .ID_BYTE_7(IDB[3]), .ID_BYTE_0(IDB[4]), .ID_BYTE_1(IDB[5])) DUT (
      .mclk(mclk), .sys_rst(sys_rst), .ce(ce), .bus_req(bus_req), .rdata(rdata),
      .timeout_interrupt(timeout_interrupt), .sys_reset_req(sys_reset_req), .irq(irq));

   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end

   // -------------------------------------------------------------------------
   // Bus and compare helpers
   // -------------------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
      @(posedge mclk);
      bus_req.wr    <= 1'b1;
      bus_req.addr  <= a;
      bus_req.wdata <= d;
      @(posedge mclk);
      bus_req.wr    <= 1'b0;
   endtask : wr_reg

   // Read data stand only in the cycle after the strobe, so sample mid-cycle.
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input bit cmp = 1);
      @(posedge mclk);
      bus_req.rd   <= 1'b1;
      bus_req.addr <= a;
      @(posedge mclk);
      bus_req.rd   <= 1'b0;
      @(negedge mclk);
      rv = rdata;
      if (cmp) begin
         chk(rv, exp);
      end
   endtask : rd_chk

   task automatic wait_raw();
      int n;
      n  = 0;
      rv = 32'h0;
      while (rv[0] !== 1'b1 && n < 100) begin
         rd_chk(`WDSL_OFS_RAW_STAT, 32'h0, 0);
         n++;
      end
   endtask : wait_raw

   // -------------------------------------------------------------------------
   // Scenarios
   // -------------------------------------------------------------------------
   task automatic t_reset();
      rd_chk(`WDSL_OFS_LOCK, `WDSL_UNLOCKED_READ);
      rd_chk(`WDSL_OFS_RAW_STAT, 32'h0);
      rd_chk(`WDSL_OFS_MASK_STAT, 32'h0);
      rd_chk(`WDSL_OFS_RELOAD, `WDSL_RELOAD_RST);
   endtask : t_reset

   task automatic t_ident();
      logic [11:0] ofs [6] = '{`WDSL_OFS_ID4, `WDSL_OFS_ID5, `WDSL_OFS_ID6,
                               `WDSL_OFS_ID7, `WDSL_OFS_ID0, `WDSL_OFS_ID1};
      for (int i = 0; i < 6; i++) begin
         wr_reg(ofs[i], {24'h0, ~IDB[i]});
         rd_chk(ofs[i], {24'h0, IDB[i]});
      end
      rd_chk(12'hfe8, 32'h0);
   endtask : t_ident

   task automatic t_lock();
      wr_reg(`WDSL_OFS_LOCK, 32'h0);
      rd_chk(`WDSL_OFS_LOCK, `WDSL_LOCKED_READ);
      wr_reg(`WDSL_OFS_RELOAD, 32'h55);
      rd_chk(`WDSL_OFS_RELOAD, `WDSL_RELOAD_RST);
      wr_reg(`WDSL_OFS_LOCK, `WDSL_UNLOCK_KEY ^ 32'h1);
      rd_chk(`WDSL_OFS_LOCK, `WDSL_LOCKED_READ);
      wr_reg(`WDSL_OFS_LOCK, `WDSL_UNLOCK_KEY);
      rd_chk(`WDSL_OFS_LOCK, `WDSL_UNLOCKED_READ);
      wr_reg(`WDSL_OFS_RELOAD, 32'd60);
      rd_chk(`WDSL_OFS_RELOAD, 32'd60);
   endtask : t_lock

   task automatic t_timeout();
      wr_reg(`WDSL_OFS_EVT_MASK, 32'h1);
      wr_reg(`WDSL_OFS_CTRL, 32'h1);
      wait_raw();
      chk(rv, 32'h1);
      rd_chk(`WDSL_OFS_MASK_STAT, 32'h1);
      chk({31'h0, irq}, 32'h1);
      wr_reg(`WDSL_OFS_EVT_MASK, 32'h0);
      rd_chk(`WDSL_OFS_EVT_STAT, 32'h1);
      chk({31'h0, irq}, 32'h0);
      wr_reg(`WDSL_OFS_EVT_MASK, 32'h1);
      wr_reg(`WDSL_OFS_LOCK, 32'h0);
      wr_reg(`WDSL_OFS_CLEAR, 32'h0);
      rd_chk(`WDSL_OFS_RAW_STAT, 32'h1);
      wr_reg(`WDSL_OFS_LOCK, `WDSL_UNLOCK_KEY);
      wr_reg(`WDSL_OFS_CLEAR, 32'h0);
      rd_chk(`WDSL_OFS_RAW_STAT, 32'h0);
      rd_chk(`WDSL_OFS_VALUE, 32'h0, 0);
      // A fresh reload leaves the count near 60; without one it would sit near 38.
      chk({31'h0, rv <= 32'd60 && rv >= 32'd45}, 32'h1);
      chk({31'h0, irq}, 32'h1);
      wr_reg(`WDSL_OFS_EVT_STAT, 32'h1);
      rd_chk(`WDSL_OFS_EVT_STAT, 32'h0);
      chk({31'h0, irq}, 32'h0);
      wait_raw();
      chk(rv, 32'h1);
      chk({31'h0, sys_reset_req}, 32'h0);
   endtask : t_timeout

   // The control word is frozen once enabled, so the reset request path needs a
   // fresh reset in mid-run before the reset enable can be set.
   task automatic t_rst_req();
      @(posedge mclk);
      sys_rst <= 1'b1;
      repeat (3) @(posedge mclk);
      sys_rst <= 1'b0;
      rd_chk(`WDSL_OFS_RAW_STAT, 32'h0);
      rd_chk(`WDSL_OFS_LOCK, `WDSL_UNLOCKED_READ);
      chk({31'h0, sys_reset_req}, 32'h0);
      @(posedge mclk);
      ce <= 1'b0;
      wr_reg(`WDSL_OFS_RELOAD, 32'd20);
      @(posedge mclk);
      ce <= 1'b1;
      rd_chk(`WDSL_OFS_RELOAD, `WDSL_RELOAD_RST);
      wr_reg(`WDSL_OFS_RELOAD, 32'd20);
      wr_reg(`WDSL_OFS_EVT_MASK, 32'h2);
      wr_reg(`WDSL_OFS_CTRL, 32'h3);
      wait_raw();
      chk(rv, 32'h1);
      chk({31'h0, sys_reset_req}, 32'h0);
      chk({31'h0, irq}, 32'h0);
      // The second timeout falls about twenty cycles after the first.
      repeat (30) @(posedge mclk);
      @(negedge mclk);
      chk({31'h0, sys_reset_req}, 32'h1);
      chk({31'h0, irq}, 32'h1);
      rd_chk(`WDSL_OFS_EVT_STAT, 32'h3);
      rd_chk(`WDSL_OFS_MASK_STAT, 32'h1);
   endtask : t_rst_req

   task automatic finish_test();
      if (err_total == 0 && checks_done > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : finish_test

   initial begin
      sys_rst     = 1'b1;
      ce          = 1'b1;
      bus_req     = '0;
      err_total   = 0;
      checks_done = 0;
      repeat (8) @(posedge mclk);
      sys_rst <= 1'b0;
      t_reset();
      t_ident();
      t_lock();
      t_timeout();
      t_rst_req();
      finish_test();
   end

   initial begin
      #20000;
      err_total++;
      finish_test();
   end
endmodule : tb_top

// ==== tb/wdsl_top_chk.sv ====
// Assertion checker for the watchdog status, lock and identification block.
// Assumes it sees only the ports of wdsl_top and is attached by the bind below.
`timescale 1ns/1ps
`include "wdsl_params.svh"

module wdsl_top_chk #(
   parameter logic [7:0] ID_BYTE_1 = 8'h18
) (
   input wire logic                    mclk,
   input wire logic                    sys_rst,
   input wire logic                    ce,
   input wire wdsl_pkg::wdsl_bus_req_t bus_req,
   input wire logic             [31:0] rdata,
   input wire logic                    timeout_interrupt,
   input wire logic                    sys_reset_req,
   input wire logic                    irq
);
   // -------------------------------------------------------------------------
   // Lock state as software sees it
   // -------------------------------------------------------------------------
   logic lock_ff;
   logic wr_ok;
   logic rd_ok;

   assign wr_ok = ce && bus_req.wr;
   assign rd_ok = ce && bus_req.rd;

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         lock_ff <= 1'b0;
      end else if (wr_ok && bus_req.addr == `WDSL_OFS_LOCK) begin
         lock_ff <= (bus_req.wdata != `WDSL_UNLOCK_KEY);
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);

   AST_LOCK_STATUS: assert property (rd_ok && bus_req.addr == `WDSL_OFS_LOCK
      |=> rdata == {31'h0, lock_ff}) else $error("lock read does not show lock state");
   AST_RAW_RESV: assert property (rd_ok && bus_req.addr == `WDSL_OFS_RAW_STAT
      |=> rdata[31:1] == 31'h0) else $error("raw status upper bits not zero");
   AST_RAW_GE_MASK: assert property (rd_ok && bus_req.addr == `WDSL_OFS_RAW_STAT
      && timeout_interrupt |=> rdata[0]) else $error("raw status clear while interrupt high");
   AST_MASK_READ: assert property (rd_ok && bus_req.addr == `WDSL_OFS_MASK_STAT
      |=> rdata == {31'h0, $past(timeout_interrupt)}) else $error("masked status mismatch");
   AST_ID_RESV: assert property (rd_ok && bus_req.addr >= `WDSL_OFS_ID4
      && bus_req.addr <= `WDSL_OFS_ID1 |=> rdata[31:8] == 24'h0)
      else $error("identification upper bits not zero");
   AST_ID_ONE: assert property (rd_ok && bus_req.addr == `WDSL_OFS_ID1
      |=> rdata == {24'h0, ID_BYTE_1}) else $error("identification byte one wrong");
   AST_LOCKED_CLEAR: assert property (wr_ok && bus_req.addr == `WDSL_OFS_CLEAR
      && lock_ff && timeout_interrupt |=> timeout_interrupt)
      else $error("locked clear write took effect");
   AST_RAW_STICKY: assert property (timeout_interrupt
      && !(wr_ok && bus_req.addr == `WDSL_OFS_CLEAR) |=> timeout_interrupt)
      else $error("timeout status dropped without clear");
   AST_RESET_QUIET: assert property ($fell(sys_rst)
      |-> !timeout_interrupt && !irq && !sys_reset_req && rdata == 32'h0)
      else $error("outputs active right after reset");

   CVR_LOCKED_READ: cover property (rd_ok && bus_req.addr == `WDSL_OFS_LOCK && lock_ff);
   CVR_TIMEOUT: cover property ($rose(timeout_interrupt));
   CVR_IRQ: cover property ($rose(irq));
   CVR_RST_REQ: cover property ($rose(sys_reset_req));
endmodule : wdsl_top_chk

bind wdsl_top wdsl_top_chk #(.ID_BYTE_1(ID_BYTE_1)) u_chk (
   .mclk(mclk), .sys_rst(sys_rst), .ce(ce), .bus_req(bus_req), .rdata(rdata),
   .timeout_interrupt(timeout_interrupt), .sys_reset_req(sys_reset_req), .irq(irq));
